//--- hdl/scd_top.sv
`timescale 1ns/1ns
`include "scd_cfg.svh"
module scd_top #(
  parameter int NCH = `SCD_NCH,
  parameter int TICK_CYC = `SCD_TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire scd_pkg::scd_mode_e mode,
  input wire logic iface_active,
  input wire logic fixed_sample_rate_sel,
  input wire logic [6:0] timer_period_value,
  input wire logic timer_start,
  input wire logic fifo_reset,
  // Frame strobe and received samples (same clock domain)
  input wire logic frame_sync,
  input wire scd_pkg::scd_rx_s rx,
  // Software memory access
  input wire scd_pkg::scd_acc_s acc,
  output logic memory_access_active,
  output logic [7:0] memory_data_reg,
  // Downstream odd-slot transmit lookup
  input wire logic [4:0] tx_chan,
  output logic [7:0] tx_data,
  // Change FIFO and timer status
  input wire logic fifo_rd,
  output logic [7:0] fifo_entry,
  output logic signaling_change_irq,
  output logic timer_active
);
  localparam int CNT_W = $clog2(TICK_CYC + 1);
  logic [7:0] actual_q [NCH];
  logic [7:0] stable_q [NCH];
  logic [7:0] last_q [NCH];
  logic [7:0] fifo_q [`SCD_FIFO_DEPTH];
  logic [3:0] cnt_q;
  logic [3:0] rp_q;
  logic [3:0] wp_q;
  logic [CNT_W-1:0] tick_q;
  logic [6:0] per_q;
  logic timer_active_q;
  logic sample_en;
  logic [7:0] val;
  logic full;
  logic is_ci;
  logic ci_chg;
  logic sig_chg;
  logic push;
  logic pop;
  logic [7:0] new_entry;
  logic [1:0] acc_cnt_q;
  logic [7:0] dn_rdata;
  scd_pkg::scd_acc_state_e acc_q;

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = (p == 4'(`SCD_FIFO_DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction

  assign is_ci = (mode == scd_pkg::SCD_CI4);
  assign full = (cnt_q == 4'(`SCD_FIFO_DEPTH));
  // Mask the value to its significant field
  always_comb begin
    unique case (mode)
      scd_pkg::SCD_CI4: val = rx.data & `SCD_CI_MASK;
      scd_pkg::SCD_SIG6: val = rx.data & `SCD_SIG6_MASK;
      default: val = rx.data;
    endcase
  end

  // Timer: period (1+value)*250us, started by command
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_active_q <= 1'b0;
      tick_q <= '0;
      per_q <= 7'h00;
    end else begin
      if (timer_start) begin
        timer_active_q <= 1'b1;
        tick_q <= '0;
        per_q <= 7'h00;
      end else if (timer_active_q) begin
        if (tick_q == CNT_W'(TICK_CYC - 1)) begin
          tick_q <= '0;
          per_q <= (per_q == timer_period_value) ? 7'h00 : per_q + 7'h01;
        end else begin
          tick_q <= tick_q + 1'b1;
        end
      end
    end
  end
  assign timer_active = timer_active_q;

  logic period_tick;
  assign period_tick = timer_active_q && tick_q == CNT_W'(TICK_CYC - 1)
                       && per_q == timer_period_value;
  logic sample_window_q;
  // Timer tick arms next frame of samples for the timer-defined rate
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_window_q <= 1'b0;
    end else if (period_tick) begin
      sample_window_q <= 1'b1;
    end else if (frame_sync) begin
      sample_window_q <= 1'b0;
    end
  end
  logic frame_window_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_window_q <= 1'b0;
    end else if (frame_sync) begin
      frame_window_q <= sample_window_q;
    end
  end
  // C/I sampled each frame while iface_active is high; SIG per selected rate
  assign sample_en = rx.valid && iface_active
    && (is_ci || fixed_sample_rate_sel || frame_window_q);

  assign ci_chg = sample_en && is_ci && val != actual_q[rx.chan];
  assign sig_chg = sample_en && !is_ci && val == last_q[rx.chan]
                   && val != stable_q[rx.chan];
  // Change blocked while full: C/I actual and SIG stable values untouched, source retries later
  assign push = (ci_chg || sig_chg) && !full;
  assign pop = fifo_rd && cnt_q != 4'h0;
  // Even address for C/I, odd address for a stable SIG value
  assign new_entry = {1'b1, 1'b0, rx.chan, ~is_ci};

  // Upstream actual/last/stable values
  always_ff @(posedge clk) begin
    if (sample_en && !(full && ci_chg)) begin
      actual_q[rx.chan] <= val;
      last_q[rx.chan] <= val;
    end
    if (push && !is_ci) begin
      stable_q[rx.chan] <= val;
    end
    if (acc.go && !acc.rd && acc_q == scd_pkg::SCD_IDLE) begin
      if (acc.odd) begin
        stable_q[acc.chan] <= acc.data;
      end else begin
        actual_q[acc.chan] <= acc.data;
        last_q[acc.chan] <= acc.data;
      end
    end
  end

  // Change address FIFO; a change in the reset cycle survives it
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
      rp_q <= 4'h0;
      wp_q <= 4'h0;
    end else if (fifo_reset) begin
      cnt_q <= 4'(push);
      rp_q <= 4'h0;
      wp_q <= push ? 4'h1 : 4'h0;
      if (push) begin
        fifo_q[0] <= new_entry;
      end
    end else begin
      if (push) begin
        fifo_q[wp_q] <= new_entry;
        wp_q <= ptr_inc(wp_q);
      end
      if (pop) begin
        rp_q <= ptr_inc(rp_q);
      end
      cnt_q <= cnt_q + 4'(push) - 4'(pop);
    end
  end
  assign fifo_entry = (cnt_q != 4'h0) ? fifo_q[rp_q] : 8'h00;
  assign signaling_change_irq = (cnt_q != 4'h0);

  // Downstream store: even slot value is sent in odd slot
  scd_mem #(.WIDTH(8), .DEPTH(NCH), .AW(5)) u_dn (
    .clk(clk),
    .we(acc.go && !acc.rd && !acc.odd && acc_q == scd_pkg::SCD_IDLE
        && acc.data[`SCD_VALID_BIT] == 1'b0),
    .waddr(acc.chan),
    .wdata(acc.data),
    .raddr(tx_chan),
    .rdata(dn_rdata)
  );
  assign tx_data = dn_rdata;

  // Software read: data loaded on the edge that raises the busy flag
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= scd_pkg::SCD_IDLE;
      acc_cnt_q <= 2'h0;
      memory_data_reg <= 8'h00;
    end else begin
      unique case (acc_q)
        scd_pkg::SCD_IDLE: if (acc.go && acc.rd) begin
          acc_q <= scd_pkg::SCD_BUSY;
          acc_cnt_q <= 2'h0;
          memory_data_reg <= acc.odd ? stable_q[acc.chan]
                                     : actual_q[acc.chan];
        end
        scd_pkg::SCD_BUSY: begin
          acc_cnt_q <= acc_cnt_q + 2'h1;
          if (acc_cnt_q == 2'(`SCD_ACC_CYC - 1)) begin
            acc_q <= scd_pkg::SCD_DONE;
          end
        end
        scd_pkg::SCD_DONE: acc_q <= scd_pkg::SCD_IDLE;
      endcase
    end
  end
  assign memory_access_active = (acc_q == scd_pkg::SCD_BUSY);

  chk_fifo_bound: assert property (@(posedge clk)
    disable iff (rst) cnt_q <= 4'(`SCD_FIFO_DEPTH))
    else $error("fifo overfill");
  chk_irq_level: assert property (@(posedge clk)
    disable iff (rst) (signaling_change_irq && !pop && !fifo_reset)
    |=> signaling_change_irq) else $error("irq dropped");
  chk_entry_msb: assert property (@(posedge clk)
    disable iff (rst) push |=> fifo_entry[7]) else $error("entry msb");
  chk_no_inactive: assert property (@(posedge clk)
    disable iff (rst) !iface_active |-> !push) else $error("inactive push");
  chk_push_count: assert property (@(posedge clk)
    disable iff (rst) (push && !pop && !fifo_reset)
    |=> cnt_q == $past(cnt_q) + 4'h1) else $error("count");
  chk_pop_count: assert property (@(posedge clk)
    disable iff (rst) (pop && !push && !fifo_reset)
    |=> cnt_q == $past(cnt_q) - 4'h1) else $error("pop");
  chk_reset_clear: assert property (@(posedge clk)
    disable iff (rst) (fifo_reset && !push) |=> !signaling_change_irq)
    else $error("reset");
  chk_acc_busy: assert property (@(posedge clk)
    disable iff (rst) (acc.go && acc.rd && acc_q == scd_pkg::SCD_IDLE)
    |=> memory_access_active [*2] ##1 !memory_access_active)
    else $error("busy");
  chk_sig_filter: assert property (@(posedge clk)
    disable iff (rst) (push && !is_ci) |-> val == last_q[rx.chan])
    else $error("filt");
  cov_full: cover property (@(posedge clk) full);
  cov_sig: cover property (@(posedge clk) push && !is_ci);
  cov_ci: cover property (@(posedge clk) push && is_ci);
  cov_timer: cover property (@(posedge clk) period_tick);
endmodule

//--- hdl/scd_cfg.svh
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
`define SCD_CLK_HZ 20000000
`define SCD_TICK_US 250
`define SCD_TICK_CYC ((`SCD_CLK_HZ / 1000000) * `SCD_TICK_US)
`define SCD_FIFO_DEPTH 9
`define SCD_NCH 32
`define SCD_VALID_BIT 7
`define SCD_SIG6_MASK 8'hFC
`define SCD_CI_MASK 8'h3C
`define SCD_ACC_CYC 2
`endif

//--- hdl/scd_pkg.sv
package scd_pkg;
  typedef enum logic [1:0] {SCD_CI4, SCD_SIG6, SCD_SIG8} scd_mode_e;
  // One upstream sample from the serial side
  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [7:0] data;
  } scd_rx_s;
  // Software memory access request
  typedef struct packed {
    logic go;
    logic rd;
    logic odd;
    logic [4:0] chan;
    logic [7:0] data;
  } scd_acc_s;
  typedef enum logic [1:0] {SCD_IDLE, SCD_BUSY, SCD_DONE} scd_acc_state_e;
endpackage

//--- hdl/scd_mem.sv
`timescale 1ns/1ns
// Small word memory with registered read data
module scd_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  // Storage write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // Registered read keeps data output clean
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule

//--- verif/scd_sub.sv
`timescale 1ns/1ns
// Subscriber side: frame strobe, then one sample per enabled channel
module scd_sub (
  // Clock
  input wire logic clk,
  // Serial side samples
  output logic frame_sync,
  output scd_pkg::scd_rx_s rx
);
  logic [7:0] val [32];
  logic on [32];
  int ph;
  initial begin
    frame_sync = 1'b0;
    rx = '0;
    ph = 0;
    for (int i = 0; i < 32; i++) begin
      val[i] = 8'h00;
      on[i] = 1'b0;
    end
  end
  // Short 40-cycle frame keeps the run brief; idle data toggles
  always @(negedge clk) begin
    ph <= (ph == 39) ? 0 : ph + 1;
    frame_sync <= (ph == 0);
    if (ph >= 2 && ph < 34 && on[ph-2]) begin
      rx <= {1'b1, 5'(ph - 2), val[ph-2]};
    end else begin
      rx.valid <= 1'b0;
      rx.data <= ~rx.data;
    end
  end
endmodule

//--- verif/test_scd_top.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  err_total++; $display("Error %s exp %h got %h", nm, ex, got); end end
module test_scd_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iface_active = 1'b0;
  logic fixed_sample_rate_sel = 1'b1;
  logic timer_start = 1'b0;
  logic fifo_reset = 1'b0;
  logic fifo_rd = 1'b0;
  logic [6:0] timer_period_value = 7'h09;
  logic [4:0] tx_chan = 5'h00;
  scd_pkg::scd_mode_e mode = scd_pkg::SCD_CI4;
  scd_pkg::scd_acc_s acc = '0;
  scd_pkg::scd_rx_s rx;
  logic frame_sync, memory_access_active, signaling_change_irq, timer_active;
  logic [7:0] memory_data_reg, tx_data, fifo_entry;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  // Short tick so timer periods fit a brief run
  scd_top #(.NCH(32), .TICK_CYC(10)) u_scd_top (.clk, .rst, .mode,
    .iface_active, .fixed_sample_rate_sel, .timer_period_value,
    .timer_start, .fifo_reset, .frame_sync, .rx, .acc,
    .memory_access_active, .memory_data_reg, .tx_chan, .tx_data,
    .fifo_rd, .fifo_entry, .signaling_change_irq, .timer_active);
  scd_sub u_scd_sub (.clk, .frame_sync, .rx);
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic cy(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Memory access; go is lowered before the next request
  task automatic op(input logic r, o, input logic [4:0] c,
      input logic [7:0] d);
    int n;
    n = 0;
    acc = {1'b1, r, o, c, d};
    @(negedge clk);
    acc.go = 1'b0;
    if (r) `CHK("busy", 1'b1, memory_access_active)
    while (memory_access_active !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK("access done", 1'b0, memory_access_active)
    if (r) `CHK("busy len", 2, n)
    cy(2);
  endtask
  // Wait for the idle gap after the last slot so value changes never race
  task automatic quiet();
    while (u_scd_sub.ph < 35) @(negedge clk);
  endtask
  task automatic pop();
    fifo_rd = 1'b1;
    cy(1);
    fifo_rd = 1'b0;
    cy(1);
  endtask
  task automatic summarize();
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_tx();
    op(1'b0, 1'b0, 5'h05, 8'h3C);
    tx_chan = 5'h05;
    cy(2);
    `CHK("tx_data", 8'h3C, tx_data)
  endtask
  task automatic t_ci();
    op(1'b0, 1'b0, 5'h03, 8'h14);
    quiet();
    u_scd_sub.val[3] = 8'h28;
    u_scd_sub.on[3] = 1'b1;
    cy(80);
    `CHK("irq idle", 1'b0, signaling_change_irq)
    u_scd_sub.val[3] = 8'h14;
    iface_active = 1'b1;
    cy(80);
    `CHK("irq match", 1'b0, signaling_change_irq)
    u_scd_sub.val[3] = 8'h28;
    cy(80);
    `CHK("irq ci", 1'b1, signaling_change_irq)
    `CHK("entry ci", 8'h86, fifo_entry)
    op(1'b1, 1'b0, 5'h03, 8'h00);
    `CHK("ci value", 8'h28, memory_data_reg)
    pop();
    `CHK("irq pop", 1'b0, signaling_change_irq)
    `CHK("entry pop", 8'h00, fifo_entry)
    u_scd_sub.on[3] = 1'b0;
  endtask
  // One-frame glitch must be filtered, a held change reported
  task automatic t_sig(input scd_pkg::scd_mode_e m, input logic [4:0] c,
      input logic [7:0] v, ex);
    mode = m;
    op(1'b0, 1'b0, c, 8'h74);
    op(1'b0, 1'b1, c, 8'h74);
    quiet();
    u_scd_sub.val[c] = 8'h33;
    u_scd_sub.on[c] = 1'b1;
    cy(40);
    u_scd_sub.val[c] = 8'h74;
    cy(120);
    `CHK("irq glitch", 1'b0, signaling_change_irq)
    u_scd_sub.val[c] = v;
    cy(120);
    `CHK("entry sig", {2'b10, c, 1'b1}, fifo_entry)
    op(1'b1, 1'b1, c, 8'h00);
    `CHK("stable", ex, memory_data_reg)
    op(1'b1, 1'b0, c, 8'h00);
    `CHK("actual", ex, memory_data_reg)
    fifo_reset = 1'b1;
    cy(1);
    fifo_reset = 1'b0;
    cy(3);
    `CHK("irq reset", 1'b0, signaling_change_irq)
    u_scd_sub.on[c] = 1'b0;
  endtask
  // Ten changes at once: the tenth waits for room
  task automatic t_full();
    mode = scd_pkg::SCD_CI4;
    for (int i = 10; i < 20; i++) begin
      op(1'b0, 1'b0, 5'(i), 8'h00);
      u_scd_sub.on[i] = 1'b1;
    end
    quiet();
    for (int i = 10; i < 20; i++) u_scd_sub.val[i] = 8'h3C;
    cy(80);
    op(1'b1, 1'b0, 5'h13, 8'h00);
    `CHK("held value", 8'h00, memory_data_reg)
    for (int i = 10; i < 20; i++) begin
      if (i == 19) cy(80);
      `CHK("entry fifo", {2'b10, 5'(i), 1'b0}, fifo_entry)
      pop();
    end
    `CHK("irq empty", 1'b0, signaling_change_irq)
    for (int i = 10; i < 20; i++) u_scd_sub.on[i] = 1'b0;
  endtask
  task automatic t_timer();
    mode = scd_pkg::SCD_SIG8;
    fixed_sample_rate_sel = 1'b0;
    u_scd_sub.val[2] = 8'h0C;
    u_scd_sub.on[2] = 1'b1;
    cy(160);
    `CHK("irq no timer", 1'b0, signaling_change_irq)
    `CHK("timer idle", 1'b0, timer_active)
    timer_start = 1'b1;
    cy(1);
    timer_start = 1'b0;
    cy(1);
    `CHK("timer run", 1'b1, timer_active)
    cy(480);
    `CHK("entry timer", 8'h85, fifo_entry)
  endtask
  // Ceiling well above the expected two thousand or so cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end
  // Reset for 12 cycles, then the scenarios in turn
  initial begin
    cy(12);
    rst = 1'b0;
    cy(2);
    t_tx();
    t_ci();
    t_sig(scd_pkg::SCD_SIG8, 5'h02, 8'h30, 8'h30);
    t_sig(scd_pkg::SCD_SIG6, 5'h04, 8'hCF, 8'hCC);
    t_full();
    t_timer();
    summarize();
  end
endmodule
